//--- src/gnss_pkg.sv
package gnss_pkg;

  localparam int CLK_PERIOD_NS   = 25;
  // crystal period expressed in core clock cycles (core_clk models 4x crystal)
  localparam int XTAL_PERIOD_CYC = 4;

  localparam int               GAIN_W        = 6;
  localparam logic [5:0]       GAIN_CODE_MAX = 6'h3F;
  localparam logic [5:0]       GAIN_CODE_MIN = 6'h00;
  localparam int               GAIN_DB_MAX   = 62;
  localparam logic [1:0]       GAIN_MODE_MANUAL = 2'h2;

  localparam int               AGC_WINDOW = 512;
  localparam int               WIN_W      = 9;
  localparam int               AGC_CNT_W  = 10;
  localparam int               GREF_W     = 12;

  localparam int               SYNTH_REFERENCE_DIVISOR_W        = 10;
  localparam logic [9:0]       SYNTH_REFERENCE_DIVISOR_MIN      = 10'h001;
  localparam int               NINT_W        = 15;
  localparam logic [14:0]      NINT_MIN      = 15'h0024;
  localparam logic [14:0]      NINT_FRAC_MAX = 15'h00FB;
  localparam int               NFRAC_W       = 20;

  localparam int               FDIV_W    = 12;
  localparam int               FDIV_SPAN = 4096;

  localparam int               LANES      = 4;
  localparam int               LANE_I_UP  = 0;
  localparam int               LANE_I_LO  = 1;
  localparam int               LANE_Q_UP  = 2;
  localparam int               LANE_Q_LO  = 3;
  localparam int               FIFO_DEPTH = 8;

  localparam logic [2:0]       BITS_1 = 3'h0;
  localparam logic [2:0]       BITS_2 = 3'h2;
  localparam logic [2:0]       BITS_3 = 3'h4;

  localparam logic [1:0]       DRV_CMOS   = 2'h0;
  localparam int               DRV_ANALOG_BIT = 1;
  localparam int               FMT_TWOS_BIT   = 1;

  typedef enum logic [1:0] {
    CKO_X2   = 2'b00,
    CKO_DIV4 = 2'b01,
    CKO_DIV2 = 2'b10,
    CKO_X1   = 2'b11
  } clkout_sel_t;

  typedef enum logic [1:0] {
    FMT_UNSIGNED = 2'b00,
    FMT_SIGNMAG  = 2'b01,
    FMT_TWOS     = 2'b10,
    FMT_TWOS_ALT = 2'b11
  } fmt_t;

endpackage

//--- src/gnss_sample_ctrl.sv
// Summary of operation
// - gain mode 10 takes amplifier gain from the manual gain word
// - automatic loop counts magnitude bits over 512 sample clocks vs reference
// - target density is reference word over window length 512
// - six-bit gain code maps 0 to 0 dB, 63 to 62 dB, ~1 dB/step
// - synthesizer reference divisor is 10 bits, 1 to 1023
// - main divider integer part 15 bits, 36 to 32767, plus 20-bit fraction
// - clock out select: 00 x2, 01 quarter, 10 half, 11 crystal
// - driver select: 00 CMOS samples, 01 reserved, 1X analog bypass
// - format: 00 unsigned, 01 sign/magnitude, 1X two's complement
// - channel enable 0 gives in-phase only, 1 gives both channels
// - width 000 one bit, 010 two bits, 100 three bits (in-phase only)
// - MSB on upper pin, LSB on lower; 3-bit LSB on quad upper
// - fractional ratio is low over (4096 minus high plus low)
// - fractional mode alternates neighbouring integer ratios to average the fraction
// - one select bit routes sample clock through or around fractional divider
// - divider select 0 uses fractional divider, 1 bypasses it
// - source bit takes sample clock before or after clock output divider stage
// - source 0 uses divider/multiplier output, 1 the raw reference clock
// - four lanes: 0,1 in-phase (sign, magnitude), 2,3 quadrature
`timescale 1ns/1ps
`default_nettype none
module gnss_sample_ctrl #(
  parameter int XTAL_CYCLES = gnss_pkg::XTAL_PERIOD_CYC,
  parameter int SAMPLE_FIFO_DEPTH = gnss_pkg::FIFO_DEPTH
) (
  input  wire logic                          core_clk,
  input  wire logic                          sys_rst,
  input  wire logic [1:0]                    gain_control_mode,
  input  wire logic [gnss_pkg::GAIN_W-1:0]   manual_gain_word,
  input  wire logic [gnss_pkg::GREF_W-1:0]   gain_reference_word,
  input  wire logic [gnss_pkg::SYNTH_REFERENCE_DIVISOR_W-1:0]   synth_reference_divisor,
  input  wire logic [gnss_pkg::NINT_W-1:0]   synth_main_integer,
  input  wire logic [gnss_pkg::NFRAC_W-1:0]  synth_main_fraction,
  input  wire logic                          synth_fractional_enable,
  input  wire logic [1:0]                    clock_output_divider_select,
  input  wire logic                          sample_clock_source,
  input  wire logic                          sample_divider_bypass,
  input  wire logic [gnss_pkg::FDIV_W-1:0]   frac_low_count,
  input  wire logic [gnss_pkg::FDIV_W-1:0]   frac_high_count,
  input  wire logic [1:0]                    output_driver_select,
  input  wire logic [1:0]                    sample_format_select,
  input  wire logic                          quadrature_channel_enable,
  input  wire logic [2:0]                    sample_width_select,
  input  wire logic [2:0]                    inphase_level,
  input  wire logic [2:0]                    quad_level,
  input  wire logic                          dsp_ready,
  input  wire logic                          overrun_clear,
  output logic      [gnss_pkg::GAIN_W-1:0]   pga_gain_code,
  output logic      [gnss_pkg::GAIN_W-1:0]   pga_gain_db,
  output logic      [gnss_pkg::AGC_CNT_W-1:0] agc_window_count,
  output logic                               agc_window_done,
  output logic                               clock_out,
  output logic                               synth_compare_tick,
  output logic                               synth_config_error,
  output logic                               sample_clock_tick,
  output logic                               analog_bypass_en,
  output logic                               inphase_upper_pin,
  output logic                               inphase_lower_pin,
  output logic                               quad_upper_pin,
  output logic                               quad_lower_pin,
  output logic                               sample_valid,
  output logic                               sample_overrun
);
  import gnss_pkg::*;

  localparam int XW = $clog2(XTAL_CYCLES);

  if (XTAL_CYCLES < 4 || (XTAL_CYCLES % 4) != 0 || XTAL_CYCLES > 16) begin : g_chk
    $error("gnss_sample_ctrl: XTAL_CYCLES must be a multiple of 4 in 4..16");
  end

  typedef struct packed {
    logic [XW-1:0]        xtal_cnt;
    logic [5:0]           cko_cnt;
    logic                 cko;
    logic [SYNTH_REFERENCE_DIVISOR_W-1:0]    synth_reference_divisor_cnt;
    logic                 comp_tick;
    logic                 cfg_err;
    logic [WIN_W-1:0]     win_cnt;
    logic [AGC_CNT_W-1:0] mag_cnt;
    logic [AGC_CNT_W-1:0] last_cnt;
    logic                 agc_done;
    logic [GAIN_W-1:0]    gain;
    logic [GAIN_W-1:0]    gain_db;
    logic                 analog;
    logic                 pend_valid;
    logic [LANES-1:0]     pend_data;
    logic [LANES-1:0]     pins;
    logic                 out_valid;
    logic                 overrun;
  } ctrl_state_t;

  ctrl_state_t      s_r;
  ctrl_state_t      s_nxt;
  logic             ref_tick;
  logic [5:0]       cko_half;
  logic             cko_toggle;
  logic             cko_rise;
  logic             src_tick;
  logic             sample_tick;
  logic             fifo_in_ready;
  logic             fifo_out_valid;
  logic [LANES-1:0] fifo_out_data;
  logic             pop;
  logic [2:0]       code_i;
  logic [2:0]       code_q;
  logic             mag_now;
  logic [AGC_CNT_W-1:0] cnt_final;
  logic             win_end;
  logic             manual;

  // quantizer level 0..7 stands for -7..+7 in odd steps
  function automatic logic [2:0] encode(input logic [2:0] lvl, input logic [1:0] fmt);
    logic [2:0] r;
    r = lvl;
    if (fmt[FMT_TWOS_BIT]) begin
      r = {~lvl[2], lvl[1:0]};
    end else if (fmt == FMT_SIGNMAG) begin
      r = lvl[2] ? {1'b0, lvl[1:0]} : {1'b1, ~lvl[1:0]};
    end
    return r;
  endfunction

  // magnitude set for the outer two levels on each side
  function automatic logic mag_bit(input logic [2:0] lvl);
    return lvl[2] ~^ lvl[1];
  endfunction

  function automatic logic [5:0] half_period(input logic [1:0] sel);
    logic [5:0] h;
    unique case (clkout_sel_t'(sel))
      CKO_X2:   h = 6'(XTAL_CYCLES / 4);
      CKO_X1:   h = 6'(XTAL_CYCLES / 2);
      CKO_DIV2: h = 6'(XTAL_CYCLES);
      CKO_DIV4: h = 6'(XTAL_CYCLES * 2);
    endcase
    return h;
  endfunction

  function automatic logic [GAIN_W-1:0] gain_to_db(input logic [GAIN_W-1:0] g);
    logic [15:0] p;
    p = 16'(g) * 16'(GAIN_DB_MAX) + 16'(GAIN_CODE_MAX >> 1);
    return GAIN_W'(p / 16'(GAIN_CODE_MAX));
  endfunction

  function automatic logic [LANES-1:0] map_lanes(input logic [2:0] ci, input logic [2:0] cq,
                                                 input logic [2:0] w, input logic iq);
    logic [LANES-1:0] l;
    l = '0;
    l[LANE_I_UP] = ci[2];
    if (w == BITS_3 && !iq) begin
      l[LANE_I_LO] = ci[1];
      l[LANE_Q_UP] = ci[0];
    end else if (w == BITS_1) begin
      l[LANE_Q_UP] = iq ? cq[2] : 1'b0;
    end else begin
      l[LANE_I_LO] = ci[1];
      l[LANE_Q_UP] = iq ? cq[2] : 1'b0;
      l[LANE_Q_LO] = iq ? cq[1] : 1'b0;
    end
    return l;
  endfunction

  assign ref_tick   = (s_r.xtal_cnt == '0);
  assign cko_half   = half_period(clock_output_divider_select);
  assign cko_toggle = (s_r.cko_cnt >= cko_half - 6'h01);
  assign cko_rise   = cko_toggle && !s_r.cko;
  assign src_tick   = sample_clock_source ? ref_tick : cko_rise;
  assign code_i     = encode(inphase_level, sample_format_select);
  assign code_q     = encode(quad_level, sample_format_select);
  assign mag_now    = mag_bit(inphase_level);
  assign cnt_final  = s_r.mag_cnt + AGC_CNT_W'(mag_now);
  assign win_end    = sample_tick && (s_r.win_cnt == WIN_W'(AGC_WINDOW - 1));
  assign manual     = (gain_control_mode == GAIN_MODE_MANUAL);
  assign pop        = fifo_out_valid && dsp_ready;

  sample_frac_divider u_frac (
    .core_clk   (core_clk),
    .sys_rst    (sys_rst),
    .in_tick    (src_tick),
    .low_count  (frac_low_count),
    .high_count (frac_high_count),
    .bypass     (sample_divider_bypass),
    .out_tick   (sample_tick)
  );

  sample_fifo #(
    .WIDTH (LANES),
    .DEPTH (SAMPLE_FIFO_DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .sys_rst   (sys_rst),
    .in_valid  (s_r.pend_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (s_r.pend_data),
    .out_valid (fifo_out_valid),
    .out_ready (dsp_ready),
    .out_data  (fifo_out_data)
  );

  always_comb begin
    s_nxt           = s_r;
    s_nxt.comp_tick = 1'b0;
    s_nxt.agc_done  = 1'b0;
    s_nxt.out_valid = 1'b0;

    // crystal rate and clock output divider
    s_nxt.xtal_cnt = (s_r.xtal_cnt == XW'(XTAL_CYCLES - 1)) ? '0 : s_r.xtal_cnt + 1'b1;
    if (cko_toggle) begin
      s_nxt.cko     = ~s_r.cko;
      s_nxt.cko_cnt = '0;
    end else begin
      s_nxt.cko_cnt = s_r.cko_cnt + 6'h01;
    end

    // comparison tick from the synthesizer reference divider
    if (ref_tick) begin
      if (s_r.synth_reference_divisor_cnt + 1'b1 >= synth_reference_divisor) begin
        s_nxt.synth_reference_divisor_cnt  = '0;
        s_nxt.comp_tick = 1'b1;
      end else begin
        s_nxt.synth_reference_divisor_cnt = s_r.synth_reference_divisor_cnt + 1'b1;
      end
    end
    s_nxt.cfg_err = (synth_reference_divisor < SYNTH_REFERENCE_DIVISOR_MIN)
                 || (synth_main_integer < NINT_MIN)
                 || (synth_fractional_enable && synth_main_integer > NINT_FRAC_MAX);

    // gain control
    if (sample_tick) begin
      s_nxt.win_cnt = s_r.win_cnt + 1'b1;
      s_nxt.mag_cnt = win_end ? '0 : cnt_final;
    end
    if (win_end) begin
      s_nxt.last_cnt = cnt_final;
      s_nxt.agc_done = 1'b1;
    end
    if (manual) begin
      s_nxt.gain = manual_gain_word;
    end else if (win_end) begin
      // density target is reference over the window length
      if (GREF_W'(cnt_final) < gain_reference_word && s_r.gain != GAIN_CODE_MAX) begin
        s_nxt.gain = s_r.gain + 1'b1;
      end else if (GREF_W'(cnt_final) > gain_reference_word && s_r.gain != GAIN_CODE_MIN) begin
        s_nxt.gain = s_r.gain - 1'b1;
      end
    end
    s_nxt.gain_db = gain_to_db(s_nxt.gain);

    // sample capture; a held sample stalls capture until the fifo takes it
    s_nxt.analog = output_driver_select[DRV_ANALOG_BIT];
    s_nxt.overrun = s_r.overrun && !overrun_clear;
    if (s_r.pend_valid && fifo_in_ready) begin
      s_nxt.pend_valid = 1'b0;
    end
    if (sample_tick && output_driver_select == DRV_CMOS) begin
      if (s_r.pend_valid && !fifo_in_ready) begin
        s_nxt.overrun = 1'b1;
      end else begin
        s_nxt.pend_valid = 1'b1;
        s_nxt.pend_data  = map_lanes(code_i, code_q, sample_width_select,
                                     quadrature_channel_enable);
      end
    end

    if (pop) begin
      s_nxt.pins      = fifo_out_data;
      s_nxt.out_valid = 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign pga_gain_code      = s_r.gain;
  assign pga_gain_db        = s_r.gain_db;
  assign agc_window_count   = s_r.last_cnt;
  assign agc_window_done    = s_r.agc_done;
  assign clock_out          = s_r.cko;
  assign synth_compare_tick = s_r.comp_tick;
  assign synth_config_error = s_r.cfg_err;
  assign sample_clock_tick  = sample_tick;
  assign analog_bypass_en   = s_r.analog;
  assign inphase_upper_pin  = s_r.pins[LANE_I_UP];
  assign inphase_lower_pin  = s_r.pins[LANE_I_LO];
  assign quad_upper_pin     = s_r.pins[LANE_Q_UP];
  assign quad_lower_pin     = s_r.pins[LANE_Q_LO];
  assign sample_valid       = s_r.out_valid;
  assign sample_overrun     = s_r.overrun;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  // helper: sample ticks since the last window end
  logic [WIN_W:0] tick_seen;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tick_seen <= '0;
    end else if (win_end) begin
      tick_seen <= '0;
    end else if (sample_tick) begin
      tick_seen <= tick_seen + 1'b1;
    end
  end

  sequence s_window_closes;
    sample_tick && tick_seen == (WIN_W+1)'(AGC_WINDOW - 1);
  endsequence

  manual_gain_a: assert property (
    manual |=> pga_gain_code == $past(manual_gain_word))
    else $error("manual gain word not applied");

  window_length_a: assert property (
    s_window_closes |=> agc_window_done)
    else $error("gain window did not close after 512 samples");

  gain_up_a: assert property (
    (!manual && win_end && GREF_W'(cnt_final) < gain_reference_word && s_r.gain != GAIN_CODE_MAX)
    |=> pga_gain_code == $past(s_r.gain) + 1'b1)
    else $error("gain did not step up on low count");

  gain_down_a: assert property (
    (!manual && win_end && GREF_W'(cnt_final) > gain_reference_word && s_r.gain != GAIN_CODE_MIN)
    |=> pga_gain_code == $past(s_r.gain) - 1'b1)
    else $error("gain did not step down on high count");

  gain_db_a: assert property (
    pga_gain_code == GAIN_CODE_MAX |-> pga_gain_db == GAIN_W'(GAIN_DB_MAX))
    else $error("full gain code not at 62 dB");

  cko_x1_a: assert property (
    (clock_output_divider_select == CKO_X1 && $stable(clock_output_divider_select)
     && XTAL_CYCLES == 4 && $rose(clock_out))
    |-> ##1 clock_out ##1 (!clock_out || clock_output_divider_select != CKO_X1))
    else $error("clock out high time wrong for crystal rate");

  frac_limit_a: assert property (
    (synth_fractional_enable && synth_main_integer > NINT_FRAC_MAX) |=> synth_config_error)
    else $error("integer ratio above fractional limit not flagged");

  raw_source_a: assert property (
    (sample_clock_source && sample_divider_bypass && ref_tick) |=> sample_clock_tick)
    else $error("raw reference tick did not reach sample clock");

  analog_mode_a: assert property (
    (output_driver_select[DRV_ANALOG_BIT] && !s_r.pend_valid)
    |=> (analog_bypass_en && !s_r.pend_valid))
    else $error("analog mode still capturing samples");

  width3_map_a: assert property (
    (sample_tick && output_driver_select == DRV_CMOS && sample_width_select == BITS_3
     && !quadrature_channel_enable && !(s_r.pend_valid && !fifo_in_ready))
    |=> s_r.pend_data[LANE_Q_UP] == $past(code_i[0]))
    else $error("three-bit LSB not on quad upper lane");

endmodule
`default_nettype wire

//--- src/sample_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module sample_fifo #(
  parameter int WIDTH = 4,
  parameter int DEPTH = 8
) (
  input  wire logic             core_clk,
  input  wire logic             sys_rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  import gnss_pkg::*;

  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_chk
    $error("sample_fifo: DEPTH must be a power of two >= 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [AW:0]                 cnt;
  } fifo_state_t;

  fifo_state_t s_r;
  fifo_state_t s_nxt;
  logic        push;
  logic        pop;

  assign in_ready  = (s_r.cnt != (AW+1)'(DEPTH));
  assign out_valid = (s_r.cnt != '0);
  assign out_data  = s_r.mem[s_r.rd];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    s_nxt = s_r;
    if (push) begin
      s_nxt.mem[s_r.wr] = in_data;
      s_nxt.wr          = s_r.wr + 1'b1;
    end
    if (pop) begin
      s_nxt.rd = s_r.rd + 1'b1;
    end
    s_nxt.cnt = s_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  fifo_bound_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    s_r.cnt <= (AW+1)'(DEPTH))
    else $error("fifo count beyond depth");

endmodule
`default_nettype wire

//--- src/sample_frac_divider.sv
`timescale 1ns/1ps
`default_nettype none
module sample_frac_divider (
  input  wire logic                      core_clk,
  input  wire logic                      sys_rst,
  input  wire logic                      in_tick,
  input  wire logic [gnss_pkg::FDIV_W-1:0] low_count,
  input  wire logic [gnss_pkg::FDIV_W-1:0] high_count,
  input  wire logic                      bypass,
  output logic                           out_tick
);
  import gnss_pkg::*;

  localparam int AW = FDIV_W + 2;

  typedef struct packed {
    logic [AW-1:0] acc;
    logic          tick;
  } div_state_t;

  div_state_t    s_r;
  div_state_t    s_nxt;
  logic [AW-1:0] span;
  logic [AW-1:0] sum;

  // ratio low / (4096 - high + low)
  assign span = AW'(FDIV_SPAN) - AW'(high_count) + AW'(low_count);
  assign sum  = s_r.acc + AW'(low_count);

  always_comb begin
    s_nxt      = s_r;
    s_nxt.tick = 1'b0;
    if (bypass) begin
      s_nxt.tick = in_tick;
      s_nxt.acc  = '0;
    end else if (in_tick) begin
      // phase accumulator gives floor/ceil periods in turn
      if (sum >= span) begin
        s_nxt.acc  = sum - span;
        s_nxt.tick = 1'b1;
      end else begin
        s_nxt.acc = sum;
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign out_tick = s_r.tick;

  div_bypass_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    bypass |=> out_tick == $past(in_tick))
    else $error("bypassed divider did not pass the input tick");

endmodule
`default_nettype wire

//--- test/dsp_sink.sv
`timescale 1ns/1ps
`default_nettype none
module dsp_sink (
  input  wire logic core_clk,
  input  wire logic sys_rst,
  input  wire logic stall,
  input  wire logic sample_valid,
  output logic      dsp_ready,
  output int        rx_count
);
  assign dsp_ready = !stall;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_count <= 0;
    end else if (sample_valid) begin
      rx_count <= rx_count + 1;
    end
  end
endmodule
`default_nettype wire

//--- test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import gnss_pkg::*;
  logic        core_clk = 1'b0, sys_rst = 1'b1, overrun_clear = 1'b0, stall = 1'b0;
  logic        sample_clock_source = 1'b1, sample_divider_bypass = 1'b1;
  logic        quadrature_channel_enable = 1'b1;
  logic [1:0]  gain_control_mode = 2'h0, clock_output_divider_select = 2'h3;
  logic [1:0]  output_driver_select = 2'h0, sample_format_select = 2'h1;
  logic [2:0]  sample_width_select = 3'h2, inphase_level = 3'h7, quad_level = 3'h0;
  logic [5:0]  manual_gain_word = 6'h00, pga_gain_code, pga_gain_db;
  logic [11:0] gain_reference_word = 12'h0AA, frac_low_count = 12'h002;
  logic [11:0] frac_high_count = 12'hFFD;
  logic [9:0]  agc_window_count;
  logic        agc_window_done, clock_out, sample_clock_tick, analog_bypass_en;
  logic        synth_fractional_enable = 1'b0, synth_compare_tick, synth_config_error;
  logic [9:0]  synth_reference_divisor = 10'h001;
  logic [14:0] synth_main_integer = 15'h004E;
  logic        inphase_upper_pin, inphase_lower_pin, quad_upper_pin, quad_lower_pin;
  logic        sample_valid, sample_overrun, dsp_ready;
  int          rx_count, bad_count = 0, tests_run = 0;

  always #12.5 core_clk = ~core_clk;

  gnss_sample_ctrl dut_u (.core_clk, .sys_rst, .gain_control_mode, .manual_gain_word,
    .gain_reference_word, .synth_reference_divisor,
    .synth_main_integer, .synth_main_fraction(20'h00000),
    .synth_fractional_enable, .clock_output_divider_select, .sample_clock_source,
    .sample_divider_bypass, .frac_low_count, .frac_high_count, .output_driver_select,
    .sample_format_select, .quadrature_channel_enable, .sample_width_select,
    .inphase_level, .quad_level, .dsp_ready, .overrun_clear, .pga_gain_code,
    .pga_gain_db, .agc_window_count, .agc_window_done, .clock_out,
    .synth_compare_tick, .synth_config_error, .sample_clock_tick, .analog_bypass_en,
    .inphase_upper_pin, .inphase_lower_pin, .quad_upper_pin, .quad_lower_pin,
    .sample_valid, .sample_overrun);

  dsp_sink sink_u (.core_clk, .sys_rst, .stall, .sample_valid, .dsp_ready, .rx_count);

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic chk(input string nm, input logic [11:0] exp, input logic [11:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic wait_on(input bit agc, input int lim);
    for (int i = 0; i < lim; i++) begin
      cyc(1);
      if (agc ? agc_window_done : sample_valid) return;
    end
    chk("wait_bound", 12'h001, 12'h000);
    conclude();
  endtask

  task automatic count_ticks(input bit ck, input int n, output int hits);
    logic p;
    p = clock_out;
    hits = 0;
    repeat (n) begin
      cyc(1);
      if (ck ? (clock_out && !p) : sample_clock_tick) hits++;
      p = clock_out;
    end
  endtask

  task automatic manual_gain;
    logic [5:0] codes [4] = '{6'h00, 6'h2B, 6'h3A, 6'h3F};
    logic [5:0] dbs [4] = '{6'h00, 6'h2A, 6'h39, 6'h3E};
    gain_control_mode = GAIN_MODE_MANUAL;
    foreach (codes[k]) begin
      manual_gain_word = codes[k];
      cyc(2);
      chk("gain_code", 12'(codes[k]), 12'(pga_gain_code));
      chk("gain_db", 12'(dbs[k]), 12'(pga_gain_db));
    end
  endtask

  task automatic clock_out_rates;
    int rises [4] = '{32, 4, 8, 16};
    int hits;
    for (int k = 0; k < 4; k++) begin
      clock_output_divider_select = 2'(k);
      cyc(20);
      count_ticks(1'b1, 64, hits);
      chk("clock_out_rises", 12'(rises[k]), 12'(hits));
    end
    clock_output_divider_select = 2'h3;
  endtask

  task automatic sample_clock_paths;
    int hits;
    count_ticks(1'b0, 480, hits);
    chk("bypass_ticks", 12'h078, 12'(hits));
    sample_divider_bypass = 1'b0;
    cyc(8);
    count_ticks(1'b0, 480, hits);
    chk("frac_ticks_2of5", 12'h001, 12'(hits >= 47 && hits <= 49));
    sample_divider_bypass = 1'b1;
    sample_clock_source = 1'b0;
    clock_output_divider_select = 2'h1;
    cyc(8);
    count_ticks(1'b0, 480, hits);
    chk("divided_source", 12'h01E, 12'(hits));
    sample_clock_source = 1'b1;
    clock_output_divider_select = 2'h3;
  endtask

  task automatic pin_map;
    logic [19:0] cases [5] = '{{2'h1, 3'h2, 1'h1, 3'h7, 3'h0, 4'h7, 4'hF},
      {2'h0, 3'h2, 1'h1, 3'h5, 3'h1, 4'h8, 4'hF}, {2'h2, 3'h2, 1'h1, 3'h3, 3'h6, 4'hD, 4'hF},
      {2'h1, 3'h4, 1'h0, 3'h5, 3'h0, 4'h2, 4'hE}, {2'h3, 3'h0, 1'h0, 3'h1, 3'h0, 4'h8, 4'h8}};
    foreach (cases[k]) begin
      {sample_format_select, sample_width_select, quadrature_channel_enable,
       inphase_level, quad_level} = cases[k][19:8];
      cyc(12);
      wait_on(1'b0, 40);
      wait_on(1'b0, 40);
      chk("lanes", 12'(cases[k][7:4] & cases[k][3:0]), 12'({inphase_upper_pin,
          inphase_lower_pin, quad_upper_pin, quad_lower_pin} & cases[k][3:0]));
    end
  endtask

  task automatic driver_modes;
    int n;
    for (int k = 1; k < 4; k++) begin
      output_driver_select = 2'(k);
      cyc(12);
      chk("analog_en", 12'(k > 1), 12'(analog_bypass_en));
      n = rx_count;
      cyc(40);
      chk("no_samples", 12'(n), 12'(rx_count));
    end
    output_driver_select = DRV_CMOS;
    cyc(4);
  endtask

  task automatic overrun_fill;
    int n;
    stall = 1'b1;
    cyc(60);
    chk("overrun", 12'h001, 12'(sample_overrun));
    output_driver_select = 2'h1;
    cyc(2);
    overrun_clear = 1'b1;
    cyc(1);
    overrun_clear = 1'b0;
    cyc(1);
    chk("overrun_clear", 12'h000, 12'(sample_overrun));
    n = rx_count;
    stall = 1'b0;
    cyc(60);
    chk("drained", 12'(n + FIFO_DEPTH + 1), 12'(rx_count));
    output_driver_select = DRV_CMOS;
  endtask

  task automatic agc_steps;
    logic [11:0] refs [3] = '{12'hFFF, 12'h000, 12'h200};
    logic [2:0] lvls [3] = '{3'h3, 3'h7, 3'h0};
    logic [9:0] cnts [3] = '{10'h000, 10'h200, 10'h200};
    logic [5:0] g, e;
    manual_gain_word = 6'h20;
    cyc(2);
    gain_control_mode = 2'h0;
    foreach (refs[k]) begin
      gain_reference_word = refs[k];
      inphase_level = lvls[k];
      wait_on(1'b1, 2100);
      g = pga_gain_code;
      e = (k == 0) ? ((g == GAIN_CODE_MAX) ? g : g + 6'h01) :
          (k == 1) ? ((g == GAIN_CODE_MIN) ? g : g - 6'h01) : g;
      wait_on(1'b1, 2100);
      chk("agc_count", 12'(cnts[k]), 12'(agc_window_count));
      chk("agc_gain", 12'(e), 12'(pga_gain_code));
    end
  endtask

  task automatic synth_checks;
    int hits = 0;
    synth_reference_divisor = 10'h003;
    cyc(4);
    repeat (120) begin
      cyc(1);
      if (synth_compare_tick) hits++;
    end
    chk("compare_ticks", 12'h00A, 12'(hits));
    chk("cfg_ok", 12'h000, 12'(synth_config_error));
    synth_fractional_enable = 1'b1;
    synth_main_integer = 15'h00FC;
    cyc(2);
    chk("frac_limit", 12'h001, 12'(synth_config_error));
    synth_fractional_enable = 1'b0;
    synth_main_integer = 15'h0023;
    cyc(2);
    chk("int_min", 12'h001, 12'(synth_config_error));
    synth_main_integer = 15'h004E;
    cyc(2);
    chk("cfg_clear", 12'h000, 12'(synth_config_error));
  endtask

  initial begin
    repeat (16) @(posedge core_clk);
    #1;
    sys_rst = 1'b0;
    cyc(4);
    manual_gain();
    clock_out_rates();
    sample_clock_paths();
    pin_map();
    driver_modes();
    overrun_fill();
    agc_steps();
    synth_checks();
    conclude();
  end
endmodule
`default_nettype wire
